// ---- hdl/fcd_consts.vh ----
/*
  Constants for the four-channel transfer controller: register decode
  codes, command and mode bit positions, reset values and idle pin levels.
  Assumes it is included by the controller module only.
*/
`ifndef FCD_CONSTS_VH
`define FCD_CONSTS_VH
// command codes on the low three address lines when address bit 3 is set
`define FCD_OP_STATUS  3'h0
`define FCD_OP_SWREQ   3'h1
`define FCD_OP_MASK1   3'h2
`define FCD_OP_MODE    3'h3
`define FCD_OP_CLRPTR  3'h4
`define FCD_OP_MCLR    3'h5
`define FCD_OP_CLRMASK 3'h6
`define FCD_OP_MASKALL 3'h7
// command register bits
`define FCD_CB_M2M  0
`define FCD_CB_DIS  2
`define FCD_CB_COMP 3
`define FCD_CB_ROT  4
// mode register: [1:0] transfer type, [2] reload, [3] step down, [5:4] mode
`define FCD_MD_AUTO 2
`define FCD_MD_DEC  3
`define FCD_XF_VERIFY 2'h0
`define FCD_XF_WRITE  2'h1
`define FCD_XF_READ   2'h2
`define FCD_M_DEMAND  2'h0
`define FCD_M_SINGLE  2'h1
`define FCD_M_BLOCK   2'h2
`define FCD_M_CASCADE 2'h3
// reset values
`define FCD_RST_CMD  8'h00
`define FCD_RST_MASK 4'hf
`define FCD_RST_TEMP 8'h00
`define FCD_RST_MODE 6'h00
`define FCD_PIN_IDLE 22'h01f000
`endif

// ---- hdl/fcd_dma.v ----
/*
  Four-channel transfer controller core: host register port, arbitration,
  hold handshake, transfer sequencing, memory copy and reload.
  Assumes every pin input is asynchronous to CORE_CLK and that bidirectional
  pins are resolved outside from the output enables.
*/
`timescale 1ns/1ps
`include "fcd_consts.vh"
module fcd_dma (
  input  wire       CORE_CLK,
  input  wire       RST_N,
  input  wire       CS_N,
  input  wire       IO_READ_N_IN,
  input  wire       IO_WRITE_N_IN,
  input  wire [3:0] A_IN,
  input  wire [7:0] D_IN,
  output wire [7:0] D_OUT,
  output wire       D_OE_N,
  output wire [7:0] A_OUT,
  output wire       A_OE_N,
  input  wire [3:0] CHANNEL_REQUEST_IN,
  output wire [3:0] CHANNEL_ACKNOWLEDGE_OUT_N,
  output wire       BUS_HOLD_REQUEST,
  input  wire       BUS_HOLD_GRANT,
  input  wire       READY,
  input  wire       END_OF_SERVICE_LINE_IN_N,
  output wire       END_OF_SERVICE_LINE_OUT_N,
  output wire       END_OF_SERVICE_LINE_OE_N,
  output wire       UPPER_ADDRESS_STROBE,
  output wire       ADDRESS_DRIVE_ENABLE,
  output wire       MEMORY_READ_STROBE_N,
  output wire       MEMORY_WRITE_STROBE_N,
  output wire       IO_READ_N_OUT,
  output wire       IO_WRITE_STROBE_N,
  output wire       CTRL_OE_N
);

  localparam ST_IDLE = 3'h0;
  localparam ST_S0   = 3'h1;
  localparam ST_S1   = 3'h2;
  localparam ST_S2   = 3'h3;
  localparam ST_S3   = 3'h4;
  localparam ST_SW   = 3'h5;
  localparam ST_S4   = 3'h6;
  localparam ST_CASC = 3'h7;

  // ==========================================================
  // pin synchronisers
  wire [21:0] pin_raw = {CHANNEL_REQUEST_IN, BUS_HOLD_GRANT, READY,
                         END_OF_SERVICE_LINE_IN_N, CS_N, IO_READ_N_IN,
                         IO_WRITE_N_IN, A_IN, D_IN};
  reg  [21:0] meta_reg;
  reg  [21:0] pin_reg;

  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      meta_reg <= `FCD_PIN_IDLE;
      pin_reg  <= `FCD_PIN_IDLE;
    end else begin
      meta_reg <= pin_raw;
      pin_reg  <= meta_reg;
    end
  end

  wire [3:0] req_s   = pin_reg[21:18];
  wire       grant_s = pin_reg[17];
  wire       ready_s = pin_reg[16];
  wire       eop_n_s = pin_reg[15];
  wire       cs_n_s  = pin_reg[14];
  wire       ior_n_s = pin_reg[13];
  wire       iow_n_s = pin_reg[12];
  wire [3:0] a_s     = pin_reg[11:8];
  wire [7:0] d_s     = pin_reg[7:0];

  // ==========================================================
  // state
  reg  [2:0]  st_reg;
  reg  [1:0]  ch_reg;
  reg  [1:0]  last_reg;
  reg         m2m_reg;
  reg         wph_reg;
  reg         hrq_reg;
  reg         ptr_reg;
  reg         ior_d_reg;
  reg         iow_d_reg;
  reg         grant_d_reg;
  reg  [3:0]  acc_a_reg;
  reg  [7:0]  acc_d_reg;
  reg  [7:0]  cmd_reg;
  reg  [3:0]  swreq_reg;
  reg  [3:0]  mask_reg;
  reg  [3:0]  tc_reg;
  reg  [3:0]  armed_reg;
  reg  [7:0]  temp_reg;
  reg  [15:0] cur_adr_reg [0:3];
  reg  [15:0] cur_cnt_reg [0:3];
  reg  [15:0] ini_adr_reg [0:3];
  reg  [15:0] ini_cnt_reg [0:3];
  reg  [5:0]  mode_reg    [0:3];

  // ==========================================================
  // host register port
  wire prog  = (st_reg == ST_IDLE) & ~cs_n_s & ~grant_s;
  wire wr_ev = prog & iow_n_s & ~iow_d_reg;
  wire rd_ev = prog & ior_n_s & ~ior_d_reg;
  wire rd_on = prog & ~ior_n_s;
  wire wr_cmd = wr_ev & acc_a_reg[3];
  wire [2:0] op = acc_a_reg[2:0];
  wire mclr = wr_cmd & (op == `FCD_OP_MCLR);
  wire [1:0] wch = acc_a_reg[2:1];

  reg  [7:0]  rd_data;
  reg  [15:0] rd_word;
  reg  [3:0]  blk;
  integer     k;
  integer     kb;
  integer     ka;

  always @* begin
    for (kb = 0; kb < 4; kb = kb + 1) begin
      blk[kb] = (mode_reg[kb][5:4] == `FCD_M_BLOCK);
    end
  end

  // pending requests; software bits only count in block mode
  wire [3:0] pend = cmd_reg[`FCD_CB_DIS] ? 4'h0 :
                    ((req_s & armed_reg & ~mask_reg) | (swreq_reg & blk));

  always @* begin
    rd_word = a_s[0] ? cur_cnt_reg[a_s[2:1]] : cur_adr_reg[a_s[2:1]];
    rd_data = 8'h00;
    if (!a_s[3]) begin
      rd_data = ptr_reg ? rd_word[15:8] : rd_word[7:0];
    end else begin
      case (a_s[2:0])
        `FCD_OP_STATUS: rd_data = {pend, tc_reg};
        `FCD_OP_MCLR:   rd_data = temp_reg;
        default:        rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // arbitration
  reg  [1:0] sel;
  reg        found;
  reg  [1:0] idx;
  wire [1:0] base = cmd_reg[`FCD_CB_ROT] ? last_reg + 2'h1 : 2'h0;

  always @* begin
    sel   = 2'h0;
    found = 1'b0;
    idx   = 2'h0;
    for (ka = 0; ka < 4; ka = ka + 1) begin
      idx = base + ka[1:0];
      if (!found && pend[idx]) begin
        sel   = idx;
        found = 1'b1;
      end
    end
  end

  // ==========================================================
  // transfer datapath
  wire [1:0]  ach     = m2m_reg ? {1'b0, wph_reg} : ch_reg;
  wire [1:0]  cch     = m2m_reg ? 2'h1 : ch_reg;
  wire [15:0] cur_a   = cur_adr_reg[ach];
  wire [15:0] step_a  = mode_reg[ach][`FCD_MD_DEC] ? cur_a - 16'h0001
                                                   : cur_a + 16'h0001;
  wire [15:0] cnt     = cur_cnt_reg[cch];
  wire        tc_now  = (cnt == 16'h0000);
  wire        last_ph = ~m2m_reg | wph_reg;
  wire [1:0]  xt      = mode_reg[ch_reg][1:0];
  wire [1:0]  md      = mode_reg[ch_reg][5:4];
  wire        ext_eop = ~eop_n_s;
  wire        fin     = (last_ph & tc_now) | ext_eop;
  wire        stop    = fin | (~m2m_reg & ((md == `FCD_M_SINGLE) |
                        ((md == `FCD_M_DEMAND) & ~req_s[ch_reg])));
  wire [3:0]  svc     = (4'h1 << ch_reg) | (4'h1 << cch);
  wire [3:0]  tc_set  = ((st_reg == ST_S4) & fin) ? svc : 4'h0;
  wire        tc_clr  = rd_ev & a_s[3] & (a_s[2:0] == `FCD_OP_STATUS);

  // ==========================================================
  // registers and sequencer
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ior_d_reg   <= 1'b1;
      iow_d_reg   <= 1'b1;
      grant_d_reg <= 1'b0;
      acc_a_reg   <= 4'h0;
      acc_d_reg   <= 8'h00;
    end else begin
      ior_d_reg   <= ior_n_s;
      iow_d_reg   <= iow_n_s;
      grant_d_reg <= grant_s;
      if (!ior_n_s || !iow_n_s) begin
        acc_a_reg <= a_s;
        acc_d_reg <= d_s;
      end
    end
    if (!RST_N || mclr) begin
      st_reg    <= ST_IDLE;
      ch_reg    <= 2'h0;
      last_reg  <= 2'h3;
      m2m_reg   <= 1'b0;
      wph_reg   <= 1'b0;
      hrq_reg   <= 1'b0;
      ptr_reg   <= 1'b0;
      cmd_reg   <= `FCD_RST_CMD;
      swreq_reg <= 4'h0;
      mask_reg  <= `FCD_RST_MASK;
      tc_reg    <= 4'h0;
      armed_reg <= 4'hf;
      temp_reg  <= `FCD_RST_TEMP;
      for (k = 0; k < 4; k = k + 1) begin
        cur_adr_reg[k] <= 16'h0000;
        cur_cnt_reg[k] <= 16'h0000;
        ini_adr_reg[k] <= 16'h0000;
        ini_cnt_reg[k] <= 16'h0000;
        mode_reg[k]    <= `FCD_RST_MODE;
      end
    end else begin
      tc_reg <= (tc_clr ? 4'h0 : tc_reg) | tc_set;
      armed_reg <= armed_reg | ~req_s;
      if ((rd_ev && !a_s[3]) || (wr_ev && !acc_a_reg[3])) begin
        ptr_reg <= ~ptr_reg;
      end
      if (wr_ev && !acc_a_reg[3]) begin
        if (acc_a_reg[0]) begin
          if (ptr_reg) begin
            ini_cnt_reg[wch][15:8] <= acc_d_reg;
            cur_cnt_reg[wch][15:8] <= acc_d_reg;
          end else begin
            ini_cnt_reg[wch][7:0] <= acc_d_reg;
            cur_cnt_reg[wch][7:0] <= acc_d_reg;
          end
        end else begin
          if (ptr_reg) begin
            ini_adr_reg[wch][15:8] <= acc_d_reg;
            cur_adr_reg[wch][15:8] <= acc_d_reg;
          end else begin
            ini_adr_reg[wch][7:0] <= acc_d_reg;
            cur_adr_reg[wch][7:0] <= acc_d_reg;
          end
        end
      end
      if (wr_cmd) begin
        case (op)
          `FCD_OP_STATUS:  cmd_reg <= acc_d_reg;
          `FCD_OP_SWREQ:   swreq_reg[acc_d_reg[1:0]] <= acc_d_reg[2];
          `FCD_OP_MASK1:   mask_reg[acc_d_reg[1:0]] <= acc_d_reg[2];
          `FCD_OP_MODE:    mode_reg[acc_d_reg[1:0]] <= acc_d_reg[7:2];
          `FCD_OP_CLRPTR:  ptr_reg <= 1'b0;
          `FCD_OP_CLRMASK: mask_reg <= 4'h0;
          `FCD_OP_MASKALL: mask_reg <= acc_d_reg[3:0];
          default:         ptr_reg <= ptr_reg;
        endcase
      end
      case (st_reg)
        ST_IDLE: begin
          wph_reg <= 1'b0;
          if (|pend) begin
            hrq_reg <= 1'b1;
            st_reg  <= ST_S0;
          end
        end
        ST_S0: begin
          if (!(|pend)) begin
            hrq_reg <= 1'b0;
            st_reg  <= ST_IDLE;
          end else if (grant_s && !grant_d_reg) begin
            ch_reg  <= sel;
            m2m_reg <= cmd_reg[`FCD_CB_M2M] & (sel == 2'h0);
            if (mode_reg[sel][5:4] == `FCD_M_CASCADE) begin
              st_reg <= ST_CASC;
            end else begin
              st_reg <= ST_S1;
            end
          end
        end
        ST_CASC: begin
          if (!req_s[ch_reg]) begin
            hrq_reg  <= 1'b0;
            last_reg <= ch_reg;
            st_reg   <= ST_IDLE;
          end
        end
        ST_S1: st_reg <= ST_S2;
        ST_S2: begin
          if (cmd_reg[`FCD_CB_COMP] && !m2m_reg) begin
            st_reg <= ST_S4;
          end else begin
            st_reg <= ST_S3;
          end
        end
        ST_S3: st_reg <= ready_s ? ST_S4 : ST_SW;
        ST_SW: begin
          if (ready_s) begin
            st_reg <= ST_S4;
          end
        end
        ST_S4: begin
          cur_adr_reg[ach] <= step_a;
          if (m2m_reg && !wph_reg) begin
            temp_reg <= d_s;
          end
          if (last_ph) begin
            cur_cnt_reg[cch] <= cnt - 16'h0001;
          end
          wph_reg <= m2m_reg & ~wph_reg & ~ext_eop;
          if (stop) begin
            hrq_reg  <= 1'b0;
            last_reg <= ch_reg;
            st_reg   <= ST_IDLE;
          end else if (m2m_reg || (step_a[15:8] != cur_a[15:8])) begin
            st_reg <= ST_S1;
          end else begin
            st_reg <= ST_S2;
          end
          if (fin) begin
            swreq_reg[ch_reg] <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
              if (svc[k]) begin
                if (mode_reg[k][`FCD_MD_AUTO]) begin
                  cur_adr_reg[k] <= ini_adr_reg[k];
                  cur_cnt_reg[k] <= ini_cnt_reg[k];
                  if (mode_reg[k][5:4] == `FCD_M_DEMAND) begin
                    armed_reg[k] <= 1'b0;
                  end
                end else begin
                  mask_reg[k] <= 1'b1;
                end
              end
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // outputs
  wire xfer   = (st_reg == ST_S1) | (st_reg == ST_S2) | (st_reg == ST_S3) |
                (st_reg == ST_SW) | (st_reg == ST_S4);
  wire rd_ph  = (st_reg == ST_S3) | (st_reg == ST_SW) | (st_reg == ST_S4);
  wire wr_ph  = (st_reg == ST_SW) | (st_reg == ST_S4);
  wire m2m_wr = m2m_reg & wph_reg;
  wire [3:0] ack = ((xfer & ~m2m_reg) | (st_reg == ST_CASC)) & grant_s ?
                   (4'h1 << ch_reg) : 4'h0;

  assign BUS_HOLD_REQUEST          = hrq_reg;
  assign CHANNEL_ACKNOWLEDGE_OUT_N = ~ack;
  assign UPPER_ADDRESS_STROBE      = (st_reg == ST_S1);
  assign ADDRESS_DRIVE_ENABLE      = xfer;
  assign A_OUT                     = cur_a[7:0];
  assign A_OE_N                    = ~xfer;
  assign D_OUT = (st_reg == ST_S1) ? cur_a[15:8] : (m2m_wr ? temp_reg : rd_data);
  assign D_OE_N = ~(rd_on | (st_reg == ST_S1) | (m2m_wr & wr_ph));
  assign CTRL_OE_N = ~xfer;
  assign MEMORY_READ_STROBE_N  = ~(rd_ph & ((m2m_reg & ~wph_reg) |
                                 (~m2m_reg & (xt == `FCD_XF_READ))));
  assign IO_WRITE_STROBE_N     = ~(wr_ph & ~m2m_reg & (xt == `FCD_XF_READ));
  assign IO_READ_N_OUT         = ~(rd_ph & ~m2m_reg & (xt == `FCD_XF_WRITE));
  assign MEMORY_WRITE_STROBE_N = ~(wr_ph & (m2m_wr |
                                 (~m2m_reg & (xt == `FCD_XF_WRITE))));
  assign END_OF_SERVICE_LINE_OUT_N = 1'b0;
  assign END_OF_SERVICE_LINE_OE_N  = ~((st_reg == ST_S4) & last_ph & tc_now);

endmodule // fcd_dma

// ---- dv/fcd_dma_props.sv ----
/*
  Pin checker for the transfer controller, bound into fcd_dma.
  Assumes one core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module fcd_dma_props (
  input wire       CORE_CLK,
  input wire       RST_N,
  input wire [3:0] CHANNEL_ACKNOWLEDGE_OUT_N,
  input wire       BUS_HOLD_REQUEST,
  input wire       BUS_HOLD_GRANT,
  input wire       ADDRESS_DRIVE_ENABLE,
  input wire       UPPER_ADDRESS_STROBE,
  input wire       D_OE_N,
  input wire       END_OF_SERVICE_LINE_OE_N,
  input wire       MEMORY_READ_STROBE_N,
  input wire       MEMORY_WRITE_STROBE_N,
  input wire       IO_READ_N_OUT,
  input wire       IO_WRITE_STROBE_N,
  input wire       CTRL_OE_N
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire strobing = !(MEMORY_READ_STROBE_N && MEMORY_WRITE_STROBE_N &&
                    IO_READ_N_OUT && IO_WRITE_STROBE_N);
  // ==========================================================
  // hold handshake and acknowledges
  sequence s_hold_raised;
    $rose(BUS_HOLD_REQUEST) && !BUS_HOLD_GRANT;
  endsequence
  sequence s_no_drive;
    !ADDRESS_DRIVE_ENABLE [*2];
  endsequence
  a_one_ack: assert property ($onehot0(~CHANNEL_ACKNOWLEDGE_OUT_N))
    else $error("two acknowledges");
  a_ack_owns_bus: assert property (!(&CHANNEL_ACKNOWLEDGE_OUT_N) |->
    BUS_HOLD_REQUEST && BUS_HOLD_GRANT) else $error("acknowledge without bus");
  a_preservice_wait: assert property (s_hold_raised |=> s_no_drive)
    else $error("drive before grant");
  a_release_clean: assert property ($fell(BUS_HOLD_REQUEST) |->
    &CHANNEL_ACKNOWLEDGE_OUT_N && !ADDRESS_DRIVE_ENABLE) else $error("dirty release");
  a_end_releases: assert property (!END_OF_SERVICE_LINE_OE_N |=>
    !BUS_HOLD_REQUEST && &CHANNEL_ACKNOWLEDGE_OUT_N) else $error("service kept");
  // ==========================================================
  // strobes and upper address
  a_read_pairing: assert property (!MEMORY_READ_STROBE_N |-> IO_READ_N_OUT)
    else $error("memory read with io read");
  a_write_pairing: assert property (!MEMORY_WRITE_STROBE_N |-> IO_WRITE_STROBE_N)
    else $error("memory write with io write");
  a_strobe_drives: assert property (strobing |-> !CTRL_OE_N && ADDRESS_DRIVE_ENABLE)
    else $error("strobe outside transfer");
  a_upper_byte: assert property (UPPER_ADDRESS_STROBE |->
    !D_OE_N ##1 !UPPER_ADDRESS_STROBE) else $error("upper strobe shape");
endmodule // fcd_dma_props

bind fcd_dma fcd_dma_props u_props (
  .CORE_CLK                 (CORE_CLK),
  .RST_N                    (RST_N),
  .CHANNEL_ACKNOWLEDGE_OUT_N(CHANNEL_ACKNOWLEDGE_OUT_N),
  .BUS_HOLD_REQUEST         (BUS_HOLD_REQUEST),
  .BUS_HOLD_GRANT           (BUS_HOLD_GRANT),
  .ADDRESS_DRIVE_ENABLE     (ADDRESS_DRIVE_ENABLE),
  .UPPER_ADDRESS_STROBE     (UPPER_ADDRESS_STROBE),
  .D_OE_N                   (D_OE_N),
  .END_OF_SERVICE_LINE_OE_N (END_OF_SERVICE_LINE_OE_N),
  .MEMORY_READ_STROBE_N     (MEMORY_READ_STROBE_N),
  .MEMORY_WRITE_STROBE_N    (MEMORY_WRITE_STROBE_N),
  .IO_READ_N_OUT            (IO_READ_N_OUT),
  .IO_WRITE_STROBE_N        (IO_WRITE_STROBE_N),
  .CTRL_OE_N                (CTRL_OE_N)
);

// ---- dv/fcd_host_model.sv ----
/*
  Host side model: grants the bus on hold request, stretches transfers
  through ready when slow, and shows changing memory data.
  Assumes the bench resolves the shared data lines.
*/
`timescale 1ns/1ps
module fcd_host_model (
  input  wire       CORE_CLK,
  input  wire       RST_N,
  input  wire       slow,
  input  wire       BUS_HOLD_REQUEST,
  output reg        BUS_HOLD_GRANT = 1'b0,
  output reg        READY = 1'b1,
  output reg  [7:0] mem_data = 8'h3c
);
  reg [1:0] delay_reg = 2'h0;
  // ==========================================================
  // grant, wait states and memory data
  always @(posedge CORE_CLK) begin
    mem_data <= RST_N ? mem_data + 8'h5b : 8'h3c;
    READY    <= !RST_N || !slow || !READY;
    if (!RST_N || !BUS_HOLD_REQUEST) begin
      BUS_HOLD_GRANT <= 1'b0;
      delay_reg      <= 2'h0;
    end else if (delay_reg == {slow, 1'b1}) begin
      BUS_HOLD_GRANT <= 1'b1;
    end else begin
      delay_reg <= delay_reg + 2'h1;
    end
  end
endmodule // fcd_host_model

// ---- dv/testbench.sv ----
/*
  Self-checking bench: register port, transfer types, priority.
  Assumes the host model grants the bus and supplies memory data.
*/
`timescale 1ns/1ps
module testbench;
  reg         CORE_CLK = 1'b0;
  reg         RST_N = 1'b0;
  reg         cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, slow = 1'b0;
  reg  [3:0]  host_a = 4'h0, req = 4'h0;
  reg  [7:0]  host_d = 8'h00;
  wire [7:0]  d_out, a_out, mem_data;
  wire [3:0]  ack_n;
  wire        d_oe_n, a_oe_n, bus_hold_request, grant, ready, eop_n, eop_oe_n, ustb, address_drive_enable;
  wire        mr_n, mw_n, ior_n, iow_n, ctrl_oe_n;
  int         n_errors = 0, n_compared = 0;
  int         n_mr, n_mw, n_ior, n_iow, n_stb, n_mrc;
  reg  [7:0]  md_h1 = 8'h00, md_h2 = 8'h00, last_rd = 8'h00;
  always #5 CORE_CLK = ~CORE_CLK;
  always @(negedge mr_n) n_mr++;
  always @(negedge mw_n) n_mw++;
  always @(negedge ior_n) n_ior++;
  always @(negedge iow_n) n_iow++;
  always @(posedge ustb) n_stb++;
  always @(posedge CORE_CLK) if (mr_n === 1'b0) n_mrc++;
  // memory data shown two cycles before a read ends is the byte that memory returned
  always @(posedge CORE_CLK) begin
    md_h1 <= mem_data;
    md_h2 <= md_h1;
    if (mr_n === 1'b0) last_rd <= md_h2;
  end

  fcd_dma u_dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CS_N(cs_n),
    .IO_READ_N_IN(rd_n & (ctrl_oe_n | ior_n)), .IO_WRITE_N_IN(wr_n & (ctrl_oe_n | iow_n)),
    .A_IN(a_oe_n ? host_a : a_out[3:0]),
    .D_IN(d_oe_n ? (cs_n ? mem_data : host_d) : d_out), .D_OUT(d_out), .D_OE_N(d_oe_n),
    .A_OUT(a_out), .A_OE_N(a_oe_n), .CHANNEL_REQUEST_IN(req),
    .CHANNEL_ACKNOWLEDGE_OUT_N(ack_n), .BUS_HOLD_REQUEST(bus_hold_request), .BUS_HOLD_GRANT(grant),
    .READY(ready), .END_OF_SERVICE_LINE_IN_N(eop_oe_n | eop_n),
    .END_OF_SERVICE_LINE_OUT_N(eop_n), .END_OF_SERVICE_LINE_OE_N(eop_oe_n),
    .UPPER_ADDRESS_STROBE(ustb), .ADDRESS_DRIVE_ENABLE(address_drive_enable),
    .MEMORY_READ_STROBE_N(mr_n), .MEMORY_WRITE_STROBE_N(mw_n),
    .IO_READ_N_OUT(ior_n), .IO_WRITE_STROBE_N(iow_n), .CTRL_OE_N(ctrl_oe_n));
  fcd_host_model u_host (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .slow(slow), .BUS_HOLD_REQUEST(bus_hold_request),
    .BUS_HOLD_GRANT(grant), .READY(ready), .mem_data(mem_data));

  // ==========================================================
  // shared tasks
  task automatic tick(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_sig(input int k); // 0 hold low, 1 any ack, 2 no ack, 3 hold high
    int i;
    for (i = 0; i < 3000; i++) begin
      if (k == 0 ? bus_hold_request === 1'b0 : k == 1 ? ack_n !== 4'hf :
          k == 2 ? ack_n === 4'hf : bus_hold_request === 1'b1) break;
      tick(1);
    end
    if (i == 3000) begin
      check("wait bound", 16'h0, 16'h1);
      complete_run();
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge CORE_CLK);
    cs_n = 1'b0; host_a = a; host_d = d; wr_n = !w; rd_n = w;
    tick(4);
    q = d_out;
    wr_n = 1'b1; rd_n = 1'b1;
    tick(4);
    cs_n = 1'b1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr(4'hc, $urandom);
    wr(a, d[7:0]);
    wr(a, d[15:8]);
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    wr(4'hc, $urandom);
    acc(1'b0, a, 8'h00, v[7:0]);
    acc(1'b0, a, 8'h00, v[15:8]);
  endtask
  task automatic prog(input logic [1:0] ch, input logic [5:0] md, input logic [15:0] ad, cn);
    wr16({1'b0, ch, 1'b0}, ad);
    wr16({1'b0, ch, 1'b1}, cn);
    wr(4'hb, {md, ch});
    wr(4'ha, {6'h0, ch});
  endtask
  task automatic xfer_case(input logic [1:0] ch, input logic [7:0] cmd, input logic [5:0] md,
      input logic [15:0] ad, cn, input logic sl, input int mr, mw, ior, iow, stb, mrc,
      input logic [15:0] ead, ecn);
    logic [15:0] v;
    logic [7:0]  q;
    wr(4'h8, cmd);
    prog(ch, md, ad, cn);
    slow = sl;
    n_mr = 0; n_mw = 0; n_ior = 0; n_iow = 0; n_stb = 0; n_mrc = 0;
    req[ch] = 1'b1;
    wait_sig(1);
    check("ack", ack_n, {12'h0, ~(4'h1 << ch)});
    req[ch] = 1'b0;
    wait_sig(0);
    tick(8);
    check("memory reads", n_mr, mr);
    check("memory writes", n_mw, mw);
    check("io reads", n_ior, ior);
    check("io writes", n_iow, iow);
    check("upper strobes", n_stb, stb);
    check("read cycles", n_mrc, mrc);
    rd16({1'b0, ch, 1'b0}, v);
    check("end address", v, ead);
    rd16({1'b0, ch, 1'b1}, v);
    check("end count", v, ecn);
    acc(1'b0, 4'h8, 8'h00, q);
    check("status", q, 16'h1 << ch);
    $display("test transfer on channel %0d done", ch);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0]  q;
    logic [15:0] v, a, c;
    logic [1:0]  ch;
    q = $urandom(32'h258e1eae);
    tick(20);
    RST_N = 1'b1;
    tick(3);
    check("hold", bus_hold_request, 16'h0);
    check("acks", ack_n, 16'hf);
    acc(1'b0, 4'h8, 8'h00, q);
    check("status", q, 16'h0);
    req = 4'hf;
    tick(30);
    check("masked hold", bus_hold_request, 16'h0);
    req = 4'h0;
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      ch = $urandom; a = $urandom; c = $urandom;
      wr16({1'b0, ch, 1'b0}, a);
      wr16({1'b0, ch, 1'b1}, c);
      rd16({1'b0, ch, 1'b0}, v);
      check("address", v, a);
      rd16({1'b0, ch, 1'b1}, v);
      check("count", v, c);
    end
    $display("test registers done");
    prog(2'd0, 6'h02, 16'h0300, 16'h0000);
    wr(4'h9, 8'h04);
    tick(30);
    check("soft request", bus_hold_request, 16'h0);
    wr(4'h9, 8'h00);
    $display("test soft request done");
    xfer_case(2'd2, 8'h00, 6'h22, 16'h00ff, 16'h0001, 1'b0, 2, 0, 0, 2, 2, 4, 16'h0101, 16'hffff);
    xfer_case(2'd1, 8'h00, 6'h2d, 16'h1000, 16'h0001, 1'b1, 0, 2, 2, 0, 2, 0, 16'h1000, 16'h0001);
    xfer_case(2'd3, 8'h00, 6'h10, 16'h0040, 16'h0000, 1'b0, 0, 0, 0, 0, 1, 0, 16'h0041, 16'hffff);
    xfer_case(2'd0, 8'h08, 6'h22, 16'h0200, 16'h0000, 1'b0, 1, 0, 0, 1, 1, 1, 16'h0201, 16'hffff);
    // memory copy of two bytes, started by a software request on channel 0
    wr(4'h8, 8'h01);
    prog(2'd0, 6'h22, 16'h0010, 16'h0001);
    prog(2'd1, 6'h21, 16'h0080, 16'h0001);
    n_mr = 0; n_mw = 0; n_ior = 0; n_iow = 0; n_stb = 0;
    wr(4'h9, 8'h04);
    wait_sig(3);
    tick(8);
    check("copy ack", ack_n, 16'hf);
    wait_sig(0);
    tick(8);
    check("copy reads", n_mr, 16'h2);
    check("copy writes", n_mw, 16'h2);
    check("copy io", n_ior + n_iow, 16'h0);
    check("copy strobes", n_stb, 16'h4);
    rd16(4'h0, v);
    check("source address", v, 16'h0012);
    rd16(4'h2, v);
    check("destination address", v, 16'h0082);
    rd16(4'h3, v);
    check("destination count", v, 16'hffff);
    acc(1'b0, 4'h8, 8'h00, q);
    check("copy status", q, 16'h3);
    acc(1'b0, 4'hd, 8'h00, q);
    check("holding byte", q, last_rd);
    wr(4'hd, $urandom);
    acc(1'b0, 4'hd, 8'h00, q);
    check("cleared holding byte", q, 16'h0);
    $display("test memory copy done");
    // cascade channel answers with acknowledge only
    prog(2'd2, 6'h30, 16'h0000, 16'h0000);
    req[2] = 1'b1;
    wait_sig(1);
    check("cascade ack", ack_n, 16'hb);
    check("cascade address enable", address_drive_enable, 16'h0);
    check("cascade strobes off", ctrl_oe_n, 16'h1);
    tick(10);
    check("cascade ack held", ack_n, 16'hb);
    req[2] = 1'b0;
    wait_sig(0);
    $display("test cascade done");
    prog(2'd1, 6'h12, 16'h0500, 16'h0000);
    prog(2'd3, 6'h12, 16'h0600, 16'h0000);
    req = 4'ha;
    wait_sig(1);
    check("first ack", ack_n, 16'hd);
    req[1] = 1'b0;
    wait_sig(2);
    wait_sig(1);
    check("second ack", ack_n, 16'h7);
    req[3] = 1'b0;
    wait_sig(0);
    tick(8);
    $display("test priority done");
    wr(4'h8, 8'h10);
    prog(2'd0, 6'h10, 16'h0000, 16'h00ff);
    prog(2'd2, 6'h10, 16'h0000, 16'h00ff);
    req = 4'h5;
    wait_sig(1);
    check("rotate first", ack_n, 16'he);
    wait_sig(2);
    wait_sig(1);
    check("rotate second", ack_n, 16'hb);
    wait_sig(2);
    wait_sig(1);
    check("rotate third", ack_n, 16'he);
    req = 4'h0;
    wait_sig(0);
    $display("test rotating priority done");
    complete_run();
  end
endmodule // testbench
